// >>> inc/ucc_pkg.sv
// constants for the upconverter control low-bits block
// assumes one 10 MHz system clock and a serial control port host
package ucc_pkg;
  // =========================================
  // register map
  localparam logic [4:0] CTRL_ONE_ADDR = 5'h00;
  localparam logic [31:0] CTRL_ONE_RESET = 32'h0000_0000;
  // open bits are not stored and read as zero
  localparam logic [31:0] CTRL_ONE_MASK = 32'h0301_2fff;
  // =========================================
  // field positions
  localparam int B_MODE_HI = 25;
  localparam int B_MODE_LO = 24;
  localparam int B_SINE = 16;
  localparam int B_AUTOCLR = 13;
  localparam int B_CLRACC = 11;
  localparam int B_RAMPLD = 10;
  localparam int B_ASK_EN = 9;
  localparam int B_ASK_AUTO = 8;
  localparam int B_DIG_PD = 7;
  localparam int B_DAC_PD = 6;
  localparam int B_REF_PD = 5;
  localparam int B_AUX_PD = 4;
  localparam int B_EXT_FAST = 3;
  localparam int B_AUTO_PD = 2;
  localparam int B_THREE_WIRE = 1;
  localparam int B_LSB_FIRST = 0;
  localparam logic [1:0] MODE_SINGLE_TONE = 2'h1;
  // =========================================
  // serial frame: 8 instruction bits, 32 data bits
  localparam int INSTR_RD_BIT = 7;
  localparam logic [5:0] CNT_INS_LAST = 6'h07;
  localparam logic [5:0] CNT_DATA_FIRST = 6'h08;
  localparam logic [5:0] CNT_LAST = 6'h27;
  localparam logic [5:0] CNT_DONE = 6'h28;
  localparam logic [4:0] IDX_TOP = 5'h1f;
  // =========================================
  // auto power-down flush length in clock cycles
  localparam int FLUSH_CYCLES_DEF = 16;
endpackage

// >>> inc/ucc_wr_if.sv
// register write/read carrier between serial port and register file
// assumes both ends share the system clock
`timescale 1ns/10ps
interface ucc_wr_if;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport port (output wr, output wdata, input rdata);
  modport regs (input wr, input wdata, output rdata);
endinterface

// >>> rtl/ucc_serial.sv
// serial control port slave, sclk sampled by the system clock
// assumes sclk far slower than clk and inputs synchronous to clk
`timescale 1ns/10ps
module ucc_serial
  import ucc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdio_in,
  input wire logic lsb_first,
  input wire logic three_wire,
  ucc_wr_if.port bus,
  output logic sdio_out,
  output logic sdio_oe_b,
  output logic sdo_out,
  output logic sdo_oe_b
);
  logic sclk_q, rd_q, hit_q, out_q, wr_q;
  logic [5:0] cnt_q;
  logic [7:0] ins_q;
  logic [31:0] sh_q, rsh_q, wd_q;
  // =========================================
  // decode
  wire rise = sclk & ~sclk_q & ~cs_b & (cnt_q != CNT_DONE);
  wire fall = ~sclk & sclk_q & ~cs_b;
  wire in_ins = cnt_q <= CNT_INS_LAST;
  wire data_ph = cnt_q >= CNT_DATA_FIRST;
  wire [7:0] ins_d = lsb_first ? {sdio_in, ins_q[7:1]} : {ins_q[6:0], sdio_in};
  wire [31:0] sh_d = lsb_first ? {sdio_in, sh_q[31:1]} : {sh_q[30:0], sdio_in};
  wire hit_d = ins_d[4:0] == CTRL_ONE_ADDR;
  wire [5:0] idx6 = cnt_q - CNT_DATA_FIRST;
  wire [4:0] idx = idx6[4:0];
  wire rd_bit = lsb_first ? rsh_q[idx] : rsh_q[IDX_TOP - idx];
  wire reading = rd_q & data_ph & ~cs_b;
  // =========================================
  // shifting
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q <= 1'b0;
      cnt_q <= 6'h00;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_b)
        cnt_q <= 6'h00;
      else if (rise)
        cnt_q <= cnt_q + 6'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ins_q <= 8'h00;
      rd_q <= 1'b0;
      hit_q <= 1'b0;
      rsh_q <= 32'h0000_0000;
    end
    else if (rise && in_ins)
    begin
      ins_q <= ins_d;
      if (cnt_q == CNT_INS_LAST)
      begin
        rd_q <= ins_d[INSTR_RD_BIT];
        hit_q <= hit_d;
        // unmapped addresses read back as zero
        rsh_q <= hit_d ? bus.rdata : 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sh_q <= 32'h0000_0000;
      wd_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      if (rise && data_ph)
        sh_q <= sh_d;
      wr_q <= rise & (cnt_q == CNT_LAST) & ~rd_q & hit_q;
      if (rise && cnt_q == CNT_LAST)
        wd_q <= sh_d;
      if (fall && reading)
        out_q <= rd_bit;
    end
  end
  // =========================================
  // pins: two-wire turns sdio around, three-wire uses sdo
  assign bus.wr = wr_q;
  assign bus.wdata = wd_q;
  assign sdio_out = out_q;
  assign sdo_out = out_q;
  assign sdio_oe_b = ~(reading & ~three_wire);
  assign sdo_oe_b = ~(reading & three_wire);
  // =========================================
  // checks
  property p_oe_three;
    !sdio_oe_b |-> !three_wire && !cs_b;
  endproperty
  a_oe_three: assert property (@(posedge clk) disable iff (!rst_b) p_oe_three)
    else $error("sdio driven in three-wire mode");
endmodule // ucc_serial

// >>> rtl/ucc_autopd.sv
// automatic transmit-idle power-down sequencer
// assumes transmit enable is synchronous to clk
`timescale 1ns/10ps
module ucc_autopd
  import ucc_pkg::*;
#(
  parameter int FLUSH_CYCLES = FLUSH_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic tx_en,
  output logic flush,
  output logic stop
);
  localparam int CW = $clog2(FLUSH_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(FLUSH_CYCLES - 1);
  if (FLUSH_CYCLES < 1)
  begin : g_chk
    $error("flush length must be at least one cycle");
  end
  typedef enum logic [1:0] {AP_RUN, AP_FLUSH, AP_STOP} ucc_ap_e;
  ucc_ap_e state_q;
  logic [CW-1:0] cnt_q;
  wire leave = tx_en | ~enable;
  // =========================================
  // sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= AP_RUN;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        AP_RUN:
          if (!leave)
          begin
            state_q <= AP_FLUSH;
            cnt_q <= '0;
          end
        AP_FLUSH:
          if (leave)
            state_q <= AP_RUN;
          else if (cnt_q == LAST)
            state_q <= AP_STOP;
          else
            cnt_q <= cnt_q + 1'b1;
        AP_STOP:
          if (leave)
            state_q <= AP_RUN;
        default:
          state_q <= AP_RUN;
      endcase
    end
  end
  assign flush = state_q == AP_FLUSH;
  assign stop = state_q == AP_STOP;
  // =========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_stop_after_flush;
    (flush && cnt_q == LAST && !leave) |=> stop;
  endproperty
  a_stop_after_flush: assert property (p_stop_after_flush)
    else $error("clocks not stopped after flush");
  property p_restart;
    (stop && tx_en) |=> !stop && !flush;
  endproperty
  a_restart: assert property (p_restart)
    else $error("clocks not restarted");
  c_stop: cover property (flush ##1 stop);
endmodule // ucc_autopd

// >>> rtl/ucc_ctrl.sv
// control function one, low half: staging, update and effects
// assumes io update, profile and pins are synchronous to CLK
`timescale 1ns/10ps
// Function
// - sine select bit routes synthesizer sine output instead of cosine.
// - bit 13 clears phase accumulator on each update or profile change.
// - bit 11 holds phase accumulator in static reset while set.
// - bit 10 reloads ramp rate timer on each update or profile change.
// - bit 9 enables keying; bit 8 picks manual or automatic only when enabled.
// - bit 7 stops digital core clocks immediately, no update needed.
// - bit 6 powers down main converter clocks and bias.
// - bit 5 powers down reference input and multiplier immediately.
// - bit 4 powers down auxiliary converter clocks and bias.
// - bit 3 selects full or fast recovery for external power-down pin.
// - bit 2 with transmit enable low flushes baseband then stops clocks.
// - stopped clocks restart once transmit enable goes high.
// - auto power-down ignored in single tone mode.
// - bit 1 picks two-wire bidirectional or three-wire input-only data pin.
// - bit 0 picks msb-first or lsb-first serial bit order.
// - mode 01 is single tone; sine select only applies there.
module ucc_ctrl
  import ucc_pkg::*;
#(
  parameter int FLUSH_CYCLES = FLUSH_CYCLES_DEF
)
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic SCLK,
  input wire logic CS_B,
  input wire logic SDIO_IN,
  output logic SDIO_OUT,
  output logic SDIO_OE_B,
  output logic SDO_OUT,
  output logic SDO_OE_B,
  input wire logic IO_UPDATE,
  input wire logic [2:0] PROFILE,
  input wire logic EXTERNAL_POWERDOWN_PIN,
  input wire logic TRANSMIT_ENABLE_PIN,
  output logic SINE_SELECT,
  output logic PHASE_ACC_SYNC_CLEAR,
  output logic PHASE_ACC_HOLD,
  output logic RAMP_TIMER_RELOAD,
  output logic AMPLITUDE_SHIFT_KEYING_EN,
  output logic AMPLITUDE_SHIFT_KEYING_AUTO,
  output logic AMPLITUDE_SHIFT_KEYING_MANUAL,
  output logic CORE_CLK_STOP,
  output logic DAC_POWERDOWN,
  output logic REFERENCE_CLOCK_INPUT_POWERDOWN,
  output logic AUX_DAC_POWERDOWN,
  output logic FULL_POWERDOWN,
  output logic FAST_POWERDOWN,
  output logic BASEBAND_FLUSH,
  output logic THREE_WIRE_MODE,
  output logic LSB_FIRST_MODE
);
  ucc_wr_if bus ();
  logic [31:0] cfr_q, act_q;
  logic [2:0] prof_q;
  logic ap_flush, ap_stop;
  logic sine_q, sync_clr_q, hold_q, ramp_q;
  logic ask_en_q, ask_auto_q, ask_man_q;
  logic core_stop_q, dac_pd_q, ref_pd_q, aux_pd_q;
  logic full_pd_q, fast_pd_q, flush_q;
  // =========================================
  // serial port
  ucc_serial u_serial (
    .clk(CLK),
    .rst_b(RST_B),
    .sclk(SCLK),
    .cs_b(CS_B),
    .sdio_in(SDIO_IN),
    .lsb_first(act_q[B_LSB_FIRST]),
    .three_wire(act_q[B_THREE_WIRE]),
    .bus(bus.port),
    .sdio_out(SDIO_OUT),
    .sdio_oe_b(SDIO_OE_B),
    .sdo_out(SDO_OUT),
    .sdo_oe_b(SDO_OE_B)
  );
  assign bus.rdata = cfr_q;
  // =========================================
  // staging and active copies
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      cfr_q <= CTRL_ONE_RESET;
    else if (bus.wr)
      cfr_q <= bus.wdata & CTRL_ONE_MASK;
  end
  // a write landing with an update is applied at the next update
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      act_q <= CTRL_ONE_RESET;
    else if (IO_UPDATE)
      act_q <= cfr_q;
  end
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      prof_q <= 3'h0;
    else
      prof_q <= PROFILE;
  end
  // =========================================
  // decode
  wire prof_chg = PROFILE != prof_q;
  wire evt = IO_UPDATE | prof_chg;
  wire single_tone = act_q[B_MODE_HI:B_MODE_LO] == MODE_SINGLE_TONE;
  wire sine_d = act_q[B_SINE] & single_tone;
  wire sync_clr_d = act_q[B_AUTOCLR] & evt;
  wire hold_d = act_q[B_CLRACC];
  wire ramp_d = act_q[B_RAMPLD] & evt;
  wire ask_en_d = act_q[B_ASK_EN];
  wire ask_auto_d = ask_en_d & act_q[B_ASK_AUTO];
  wire ask_man_d = ask_en_d & ~act_q[B_ASK_AUTO];
  // immediate bits read the staging copy directly
  wire core_stop_d = cfr_q[B_DIG_PD] | ap_stop;
  wire ref_pd_d = cfr_q[B_REF_PD];
  wire full_pd_d = EXTERNAL_POWERDOWN_PIN & ~act_q[B_EXT_FAST];
  wire fast_pd_d = EXTERNAL_POWERDOWN_PIN & act_q[B_EXT_FAST];
  wire ap_en = act_q[B_AUTO_PD] & ~single_tone;
  // =========================================
  // transmit-idle power-down
  ucc_autopd #(
    .FLUSH_CYCLES(FLUSH_CYCLES)
  ) u_autopd (
    .clk(CLK),
    .rst_b(RST_B),
    .enable(ap_en),
    .tx_en(TRANSMIT_ENABLE_PIN),
    .flush(ap_flush),
    .stop(ap_stop)
  );
  // =========================================
  // registered outputs
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sine_q <= 1'b0;
      sync_clr_q <= 1'b0;
      hold_q <= 1'b0;
      ramp_q <= 1'b0;
      ask_en_q <= 1'b0;
      ask_auto_q <= 1'b0;
      ask_man_q <= 1'b0;
    end
    else
    begin
      sine_q <= sine_d;
      sync_clr_q <= sync_clr_d;
      hold_q <= hold_d;
      ramp_q <= ramp_d;
      ask_en_q <= ask_en_d;
      ask_auto_q <= ask_auto_d;
      ask_man_q <= ask_man_d;
    end
  end
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      core_stop_q <= 1'b0;
      dac_pd_q <= 1'b0;
      ref_pd_q <= 1'b0;
      aux_pd_q <= 1'b0;
      full_pd_q <= 1'b0;
      fast_pd_q <= 1'b0;
      flush_q <= 1'b0;
    end
    else
    begin
      core_stop_q <= core_stop_d;
      dac_pd_q <= act_q[B_DAC_PD];
      ref_pd_q <= ref_pd_d;
      aux_pd_q <= act_q[B_AUX_PD];
      full_pd_q <= full_pd_d;
      fast_pd_q <= fast_pd_d;
      flush_q <= ap_flush;
    end
  end
  assign SINE_SELECT = sine_q;
  assign PHASE_ACC_SYNC_CLEAR = sync_clr_q;
  assign PHASE_ACC_HOLD = hold_q;
  assign RAMP_TIMER_RELOAD = ramp_q;
  assign AMPLITUDE_SHIFT_KEYING_EN = ask_en_q;
  assign AMPLITUDE_SHIFT_KEYING_AUTO = ask_auto_q;
  assign AMPLITUDE_SHIFT_KEYING_MANUAL = ask_man_q;
  assign CORE_CLK_STOP = core_stop_q;
  assign DAC_POWERDOWN = dac_pd_q;
  assign REFERENCE_CLOCK_INPUT_POWERDOWN = ref_pd_q;
  assign AUX_DAC_POWERDOWN = aux_pd_q;
  assign FULL_POWERDOWN = full_pd_q;
  assign FAST_POWERDOWN = fast_pd_q;
  assign BASEBAND_FLUSH = flush_q;
  assign THREE_WIRE_MODE = act_q[B_THREE_WIRE];
  assign LSB_FIRST_MODE = act_q[B_LSB_FIRST];
  // =========================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_sine;
    IO_UPDATE |-> ##2 SINE_SELECT == $past(cfr_q[B_SINE] &&
      cfr_q[B_MODE_HI:B_MODE_LO] == MODE_SINGLE_TONE, 2);
  endproperty
  a_sine: assert property (p_sine) else $error("sine select mismatch");
  property p_autoclr;
    evt |=> PHASE_ACC_SYNC_CLEAR == $past(act_q[B_AUTOCLR]);
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("autoclear wrong");
  property p_hold;
    (IO_UPDATE && cfr_q[B_CLRACC]) |-> ##2 PHASE_ACC_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("accumulator not held");
  property p_ramp;
    (evt && act_q[B_RAMPLD]) |=> RAMP_TIMER_RELOAD;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp timer not reloaded");
  property p_ask;
    (AMPLITUDE_SHIFT_KEYING_AUTO || AMPLITUDE_SHIFT_KEYING_MANUAL) |->
      AMPLITUDE_SHIFT_KEYING_EN &&
      !(AMPLITUDE_SHIFT_KEYING_AUTO && AMPLITUDE_SHIFT_KEYING_MANUAL);
  endproperty
  a_ask: assert property (p_ask) else $error("keying select invalid");
  property p_core_stop;
    (bus.wr && bus.wdata[B_DIG_PD] && !IO_UPDATE) |-> ##2 CORE_CLK_STOP;
  endproperty
  a_core_stop: assert property (p_core_stop) else $error("core clock not stopped");
  property p_dac;
    IO_UPDATE |-> ##2 DAC_POWERDOWN == $past(cfr_q[B_DAC_PD], 2);
  endproperty
  a_dac: assert property (p_dac) else $error("dac power-down mismatch");
  property p_ref;
    (bus.wr && !IO_UPDATE) |-> ##2 REFERENCE_CLOCK_INPUT_POWERDOWN ==
      $past(bus.wdata[B_REF_PD], 2);
  endproperty
  a_ref: assert property (p_ref) else $error("reference power-down late");
  property p_ext;
    EXTERNAL_POWERDOWN_PIN |=> FAST_POWERDOWN == $past(act_q[B_EXT_FAST]) &&
      FULL_POWERDOWN == !$past(act_q[B_EXT_FAST]);
  endproperty
  a_ext: assert property (p_ext) else $error("external power-down mode wrong");
  property p_single_tone_ap;
    single_tone |=> ##1 !BASEBAND_FLUSH;
  endproperty
  a_single_tone_ap: assert property (p_single_tone_ap)
    else $error("auto power-down active in single tone");
  property p_stage;
    !IO_UPDATE |=> $stable(act_q);
  endproperty
  a_stage: assert property (p_stage) else $error("active copy changed");
  c_autoclr: cover property (PHASE_ACC_SYNC_CLEAR);
  c_single_sine: cover property (SINE_SELECT);
  c_ask_auto: cover property (AMPLITUDE_SHIFT_KEYING_AUTO);
  c_auto_stop: cover property (ap_stop ##1 CORE_CLK_STOP);
  // =========================================
  // idle, release and tracking checks: nothing except FULL_POWERDOWN and FAST_POWERDOWN pulses or sticks without its cause,
  // and aux, flush, stop, wire mode and bit order follow their causes
  property p_aux;
    IO_UPDATE |-> ##2 AUX_DAC_POWERDOWN == $past(cfr_q[B_AUX_PD], 2);
  endproperty
  a_aux: assert property (p_aux) else $error("aux power-down mismatch");
  property p_hold_off;
    (IO_UPDATE && !cfr_q[B_CLRACC]) |-> ##2 !PHASE_ACC_HOLD;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("accumulator held");
  property p_autoclr_idle;
    !evt |=> !PHASE_ACC_SYNC_CLEAR;
  endproperty
  a_autoclr_idle: assert property (p_autoclr_idle) else $error("stray clear");
  property p_ramp_idle;
    !evt |=> !RAMP_TIMER_RELOAD;
  endproperty
  a_ramp_idle: assert property (p_ramp_idle) else $error("stray reload");
  property p_flush;
    ap_flush |=> BASEBAND_FLUSH;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not shown");
  property p_auto_stop;
    ap_stop |=> CORE_CLK_STOP;
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("auto stop not shown");
  property p_auto_restart;
    (ap_stop && TRANSMIT_ENABLE_PIN && !cfr_q[B_DIG_PD] && !bus.wr) |=> ##1 !CORE_CLK_STOP;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("clocks left stopped");
  property p_tx_idle;
    TRANSMIT_ENABLE_PIN |=> ##1 !BASEBAND_FLUSH;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("flush with transmit on");
  property p_three;
    IO_UPDATE |=> THREE_WIRE_MODE == $past(cfr_q[B_THREE_WIRE]);
  endproperty
  a_three: assert property (p_three) else $error("wire mode mismatch");
  property p_lsb;
    IO_UPDATE |=> LSB_FIRST_MODE == $past(cfr_q[B_LSB_FIRST]);
  endproperty
  a_lsb: assert property (p_lsb) else $error("bit order mismatch");
  property p_ask_idle;
    !AMPLITUDE_SHIFT_KEYING_EN |-> !AMPLITUDE_SHIFT_KEYING_AUTO && !AMPLITUDE_SHIFT_KEYING_MANUAL;
  endproperty
  a_ask_idle: assert property (p_ask_idle) else $error("keying without enable");
  property p_sine_mode;
    !single_tone |=> !SINE_SELECT;
  endproperty
  a_sine_mode: assert property (p_sine_mode) else $error("sine outside single tone");
endmodule // ucc_ctrl

// >>> verification/ucc_host.sv
// serial host model that programs the control port frame by frame
// assumes the system clock paces it and that the bench resolves the data wire
`timescale 1ns/10ps
module ucc_host
(
  input wire logic clk,
  output logic sclk,
  output logic cs_b,
  output logic sdio_d,
  input wire logic sdio_w,
  input wire logic sdo
);
  initial
  begin
    sclk = 1'b0;
    cs_b = 1'b1;
    sdio_d = 1'b0;
  end
  // =========================================
  // whole frame, 8 instruction then 32 data bits
  // sclk phases of 3 cycles, above the 2 the port needs
  task automatic xfer(input logic rd, input logic [4:0] adr, input logic [31:0] wd,
    input logic lsb, input logic three, output logic [31:0] rv);
    logic [7:0] ins;
    int k;
    ins = {rd, 2'h0, adr};
    rv = 32'h0;
    @(posedge clk);
    cs_b <= 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      k = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : 39 - i);
      @(posedge clk);
      sclk <= 1'b0;
      if (i < 8)
        sdio_d <= ins[k];
      else if (!rd)
        sdio_d <= wd[k];
      else
        sdio_d <= ~sdio_d; // released: never a stale level
      repeat (3) @(posedge clk);
      if (rd && i >= 8)
        rv[k] = three ? sdo : sdio_w;
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    sclk <= 1'b0;
    cs_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule // ucc_host

// >>> verification/testbench.sv
// self-checking bench for the control function one low half
// assumes the host model drives the serial pins and the bench drives the rest
`timescale 1ns/10ps
module testbench;
  import ucc_pkg::*;
  localparam int FL = 3;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sclk, cs_b, sdio_d, sdio_w, sdio_out, sdio_oe_b, sdo_out, sdo_oe_b;
  logic io_update = 1'b0;
  logic [2:0] profile = 3'h0;
  logic ext_pd = 1'b0;
  logic tx_en = 1'b1;
  logic sine, sync_clr, acc_hold, ramp_ld, ask_en, ask_auto, ask_man, core_stop;
  logic dac_pd, ref_pd, aux_pd, full_pd, fast_pd, bb_flush, three_w, lsb_f;
  logic lsb_m = 1'b0;
  logic three_m = 1'b0;
  logic [31:0] tbl [7] = '{32'h0101_0000, 32'h0001_0b08, 32'h0000_0250,
    32'h0000_01a2, 32'h0000_0003, 32'hfeff_ffff, 32'h0000_0001};
  int bad_count = 0;
  int checked = 0;
  always #50 clk = ~clk;
  assign sdio_w = !sdio_oe_b ? sdio_out : sdio_d;
  ucc_host host (.clk(clk), .sclk(sclk), .cs_b(cs_b), .sdio_d(sdio_d), .sdio_w(sdio_w),
    .sdo(sdo_out));
  ucc_ctrl #(.FLUSH_CYCLES(FL)) dut (.CLK(clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b),
    .SDIO_IN(sdio_w), .SDIO_OUT(sdio_out), .SDIO_OE_B(sdio_oe_b), .SDO_OUT(sdo_out),
    .SDO_OE_B(sdo_oe_b), .IO_UPDATE(io_update), .PROFILE(profile),
    .EXTERNAL_POWERDOWN_PIN(ext_pd), .TRANSMIT_ENABLE_PIN(tx_en), .SINE_SELECT(sine),
    .PHASE_ACC_SYNC_CLEAR(sync_clr), .PHASE_ACC_HOLD(acc_hold), .RAMP_TIMER_RELOAD(ramp_ld),
    .AMPLITUDE_SHIFT_KEYING_EN(ask_en), .AMPLITUDE_SHIFT_KEYING_AUTO(ask_auto),
    .AMPLITUDE_SHIFT_KEYING_MANUAL(ask_man), .CORE_CLK_STOP(core_stop),
    .DAC_POWERDOWN(dac_pd), .REFERENCE_CLOCK_INPUT_POWERDOWN(ref_pd),
    .AUX_DAC_POWERDOWN(aux_pd), .FULL_POWERDOWN(full_pd), .FAST_POWERDOWN(fast_pd),
    .BASEBAND_FLUSH(bb_flush), .THREE_WIRE_MODE(three_w), .LSB_FIRST_MODE(lsb_f));
  // =========================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] rv;
    host.xfer(1'b0, a, v, lsb_m, three_m, rv);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] rv);
    host.xfer(1'b1, a, 32'h0, lsb_m, three_m, rv);
  endtask
  task automatic upd();
    @(posedge clk);
    io_update <= 1'b1;
    @(posedge clk);
    io_update <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // serial mode bits only bite after the update, so track them here
  task automatic set(input logic [31:0] v);
    wr(5'h00, v);
    upd();
    lsb_m = v[B_LSB_FIRST];
    three_m = v[B_THREE_WIRE];
  endtask
  task automatic ev(input int kind, output int ns, output int nr);
    ns = 0;
    nr = 0;
    @(posedge clk);
    if (kind == 0)
      io_update <= 1'b1;
    else
      profile <= profile + 3'h1;
    @(posedge clk);
    io_update <= 1'b0;
    repeat (5)
    begin
      #1;
      ns += int'(sync_clr !== 1'b0);
      nr += int'(ramp_ld !== 1'b0);
      @(posedge clk);
    end
  endtask
  task automatic tx_drop(output int nf);
    nf = 0;
    @(posedge clk);
    tx_en <= 1'b0;
    repeat (12)
    begin
      @(posedge clk);
      #1;
      nf += int'(bb_flush !== 1'b0);
    end
  endtask
  task automatic check_all(input logic [31:0] v);
    logic [31:0] rv;
    chk("sine", sine, v[B_SINE] & (v[B_MODE_HI:B_MODE_LO] == MODE_SINGLE_TONE));
    chk("hold", acc_hold, v[B_CLRACC]);
    chk("ask_en", ask_en, v[B_ASK_EN]);
    chk("ask_auto", ask_auto, v[B_ASK_EN] & v[B_ASK_AUTO]);
    chk("ask_man", ask_man, v[B_ASK_EN] & ~v[B_ASK_AUTO]);
    chk("core_stop", core_stop, v[B_DIG_PD]);
    chk("dac_pd", dac_pd, v[B_DAC_PD]);
    chk("ref_pd", ref_pd, v[B_REF_PD]);
    chk("aux_pd", aux_pd, v[B_AUX_PD]);
    chk("full_pd", full_pd, ext_pd & ~v[B_EXT_FAST]);
    chk("fast_pd", fast_pd, ext_pd & v[B_EXT_FAST]);
    chk("three_w", three_w, v[B_THREE_WIRE]);
    chk("lsb_f", lsb_f, v[B_LSB_FIRST]);
    rd(5'h00, rv);
    chk("readback", rv, v & CTRL_ONE_MASK);
  endtask
  // =========================================
  // main sequence
  initial
  begin : main
    logic [31:0] rv;
    int ns, nr, nf;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk("sdio_oe_b", sdio_oe_b, 1'b1);
    chk("sdo_oe_b", sdo_oe_b, 1'b1);
    check_all(32'h0);
    ext_pd <= 1'b1;
    // immediate bits act before the update, staged ones wait
    wr(5'h00, 32'h0000_00e0);
    repeat (3) @(posedge clk);
    chk("core_imm", core_stop, 1'b1);
    chk("ref_imm", ref_pd, 1'b1);
    chk("dac_staged", dac_pd, 1'b0);
    upd();
    chk("dac_upd", dac_pd, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      set(tbl[i]);
      check_all(tbl[i]);
    end
    wr(5'h01, 32'h0000_0fff);
    rd(5'h00, rv);
    chk("unmapped_wr", rv, tbl[6] & CTRL_ONE_MASK);
    rd(5'h01, rv);
    chk("unmapped_rd", rv, 32'h0);
    set(32'h0000_2400);
    for (int k = 0; k < 2; k++)
    begin
      ev(k, ns, nr);
      chk("sync_clr_n", ns, 1);
      chk("ramp_ld_n", nr, 1);
    end
    set(32'h0);
    ev(1, ns, nr);
    chk("sync_clr_off", ns, 0);
    chk("ramp_ld_off", nr, 0);
    set(32'h0000_0004);
    tx_drop(nf);
    chk("flush_len", nf, FL);
    chk("auto_stop", core_stop, 1'b1);
    @(posedge clk);
    tx_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("restart", core_stop, 1'b0);
    set(32'h0100_0004);
    tx_drop(nf);
    chk("tone_flush", nf, 0);
    chk("tone_stop", core_stop, 1'b0);
    @(posedge clk);
    tx_en <= 1'b1;
    close_out();
  end
  initial
  begin : watchdog
    repeat (40000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule // testbench
